// File: hdl/rod_dec_core.v
`timescale 1ns/1ps
`include "rod_regs.vh"
// combinational decode of one opcode with its modrm byte
module rod_dec_core (
  input  wire [7:0] opcode,
  input  wire [7:0] modrm,
  input  wire       esc_0f,
  input  wire       long_mode,
  input  wire       carry_flag,
  output reg        invalid_opcode_fault,
  output reg        is_nop,
  output reg        needs_modrm,
  output reg        set_low_acc_from_carry_hit,
  output reg  [7:0] low_accumulator_byte,
  output reg  [7:0] eff_opcode,
  output reg  [2:0] eff_opreg
);
  // op/reg field of modrm
  wire [2:0] opreg = modrm[5:3];

  // shift group opcode check, used once below
  function is_shift;
    input [7:0] op;
    begin
      is_shift = (op == 8'hc0) || (op == 8'hc1) || (op == 8'hd0) ||
                 (op == 8'hd1) || (op == 8'hd2) || (op == 8'hd3);
    end
  endfunction

  always @* begin
    invalid_opcode_fault = 1'b0;
    is_nop               = 1'b0;
    needs_modrm          = 1'b0;
    set_low_acc_from_carry_hit             = 1'b0;
    low_accumulator_byte = 8'h00;
    eff_opcode           = opcode;
    eff_opreg            = opreg;
    if (esc_0f) begin
      if (opcode == `ROD_OP_RNOP ||
          (opcode >= 8'h18 && opcode <= 8'h1f)) begin
        is_nop = 1'b1;
        needs_modrm = 1'b1;
      end else if (opcode == `ROD_OP_TESTREG1 ||
                   opcode == `ROD_OP_TESTREG2 ||
                   opcode == `ROD_OP_UD2) begin
        invalid_opcode_fault = 1'b1;
      end else begin
        invalid_opcode_fault = 1'b1;
      end
    end else if (opcode == `ROD_OP_GRP1A) begin
      if (long_mode) begin
        invalid_opcode_fault = 1'b1;
      end else begin
        eff_opcode  = `ROD_OP_GRP1;
        needs_modrm = 1'b1;
      end
    end else if (is_shift(opcode)) begin
      needs_modrm = 1'b1;
      // /6 behaves as left shift /4
      if (opreg == 3'b110)
        eff_opreg = 3'b100;
    end else if (opcode == `ROD_OP_TEST8 || opcode == `ROD_OP_TEST32) begin
      needs_modrm = 1'b1;
      if (opreg == 3'b001)
        eff_opreg = 3'b000;
    end else if (opcode == `ROD_OP_SET_LOW_ACC_FROM_CARRY) begin
      if (long_mode) begin
        // no carry spread in long mode
        invalid_opcode_fault = 1'b1;
      end else begin
        set_low_acc_from_carry_hit             = 1'b1;
        low_accumulator_byte = carry_flag ? `ROD_ALL_ONES : 8'h00;
      end
    end else if (opcode == `ROD_OP_GRP1) begin
      needs_modrm = 1'b1;
    end
  end
endmodule

// File: hdl/rod_regs.vh
`ifndef ROD_REGS_VH
`define ROD_REGS_VH
// apb register byte offsets
`define ROD_CTRL_OFF      12'h000
`define ROD_INSN_OFF      12'h004
`define ROD_RES_OFF       12'h008
`define ROD_FEAT_OFF      12'h00c
`define ROD_FAM_OFF       12'h010
`define ROD_FLAGS_OFF     12'h014
`define ROD_STAT_OFF      12'h018
// control register fields
`define ROD_CTRL_LONG     0
`define ROD_CTRL_CARRY    1
`define ROD_CTRL_GO       2
// instruction word fields
`define ROD_INSN_ESC      16
`define ROD_INSN_PFX      17
// feature bit positions
`define ROD_FB_FPU        0
`define ROD_FB_TSC        4
`define ROD_FB_MSR        5
`define ROD_FB_CX8        8
`define ROD_FB_CMOV       15
`define ROD_FB_MMX        23
`define ROD_FAM_LO        8
`define ROD_FAM_VAL       4'h6
`define ROD_IDF_BIT       21
// opcodes
`define ROD_OP_GRP1       8'h80
`define ROD_OP_GRP1A      8'h82
`define ROD_OP_SET_LOW_ACC_FROM_CARRY       8'hd6
`define ROD_OP_TEST8      8'hf6
`define ROD_OP_TEST32     8'hf7
`define ROD_OP_RNOP       8'h0d
`define ROD_OP_TESTREG1   8'h24
`define ROD_OP_TESTREG2   8'h26
`define ROD_OP_UD2        8'h0b
// reset values
`define ROD_CTRL_RST      3'h0
`define ROD_FLAGS_RST     32'h0000_0002
`define ROD_ALL_ONES      8'hff
`define ROD_OPC_RESULT    4'h0
`endif

// File: hdl/rod_top.v
`timescale 1ns/1ps
`include "rod_regs.vh"
module rod_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         invalid_opcode_fault,
  output reg         nop_retire,
  output reg  [7:0]  low_acc_out
);
  // control, instruction and result state
  reg  [2:0]  ctrl_r;          // long mode, carry, go
  reg  [17:0] insn_r;          // opcode, modrm, escape, prefix
  reg  [31:0] res_r;           // latched decode result
  reg  [31:0] flags_r;         // flags image, only id bit writable
  reg  [1:0]  stat_r;          // fault and nop sticky seen bits
  reg  [31:0] rdata_nxt;
  reg         hit_nxt;

  // decode outputs
  wire       dec_fault;
  wire       dec_nop;
  wire       dec_modrm;
  wire       dec_set_low_acc_from_carry;
  wire [7:0] dec_acc;
  wire [7:0] dec_op;
  wire [2:0] dec_reg;

  wire go = ctrl_r[`ROD_CTRL_GO];

  // write lands on the edge where the master samples pready high,
  // read data is captured one edge earlier so it stands at that edge
  wire wr_en = psel & penable & pwrite & pready;
  wire rd_en = psel & penable & ~pwrite & ~pready;

  rod_dec_core u_core (
    .opcode               (insn_r[7:0]),
    .modrm                (insn_r[15:8]),
    .esc_0f               (insn_r[`ROD_INSN_ESC]),
    .long_mode            (ctrl_r[`ROD_CTRL_LONG]),
    .carry_flag           (ctrl_r[`ROD_CTRL_CARRY]),
    .invalid_opcode_fault (dec_fault),
    .is_nop               (dec_nop),
    .needs_modrm          (dec_modrm),
    .set_low_acc_from_carry_hit             (dec_set_low_acc_from_carry),
    .low_accumulator_byte (dec_acc),
    .eff_opcode           (dec_op),
    .eff_opreg            (dec_reg)
  );

  // feature word is constant; float move needs bits 0 and 15 together
  wire [31:0] feat_word;
  assign feat_word = (32'h1 << `ROD_FB_FPU) | (32'h1 << `ROD_FB_TSC) |
                     (32'h1 << `ROD_FB_MSR) | (32'h1 << `ROD_FB_CX8) |
                     (32'h1 << `ROD_FB_CMOV) | (32'h1 << `ROD_FB_MMX);
  wire [31:0] fam_word = {20'h0, `ROD_FAM_VAL, 8'h00};

  // register read mux
  always @* begin
    rdata_nxt = 32'h0000_0000;
    hit_nxt   = 1'b1;
    case (paddr)
      `ROD_CTRL_OFF:  rdata_nxt = {29'h0, ctrl_r};
      `ROD_INSN_OFF:  rdata_nxt = {14'h0, insn_r};
      `ROD_RES_OFF:   rdata_nxt = res_r;
      `ROD_FEAT_OFF:  rdata_nxt = feat_word;
      `ROD_FAM_OFF:   rdata_nxt = fam_word;
      `ROD_FLAGS_OFF: rdata_nxt = flags_r;
      `ROD_STAT_OFF:  rdata_nxt = {30'h0, stat_r};
      default:        hit_nxt   = 1'b0;
    endcase
  end

  // apb answer one cycle into access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_nxt;
      if (rd_en)
        prdata <= rdata_nxt;
    end
  end

  // software writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `ROD_CTRL_RST;
      insn_r  <= 18'h00000;
      flags_r <= `ROD_FLAGS_RST;
    end else begin
      if (wr_en && paddr == `ROD_CTRL_OFF)
        ctrl_r <= pwdata[2:0];
      else if (go)
        ctrl_r[`ROD_CTRL_GO] <= 1'b0;   // go is self clearing
      if (wr_en && paddr == `ROD_INSN_OFF)
        insn_r <= pwdata[17:0];
      if (wr_en && paddr == `ROD_FLAGS_OFF)
        flags_r[`ROD_IDF_BIT] <= pwdata[`ROD_IDF_BIT];
    end
  end

  // decode execution: one go pulse retires one instruction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r                <= 32'h0000_0000;
      stat_r               <= 2'b00;
      invalid_opcode_fault <= 1'b0;
      nop_retire           <= 1'b0;
      low_acc_out          <= 8'h00;
    end else begin
      invalid_opcode_fault <= go & dec_fault;
      nop_retire           <= go & dec_nop;
      if (go) begin
        res_r <= {4'h0, dec_set_low_acc_from_carry, dec_modrm, dec_nop, dec_fault,
                  insn_r[`ROD_INSN_PFX], dec_reg, dec_op, dec_acc, 4'h0};
        // low byte only on carry spread
        if (dec_set_low_acc_from_carry)
          low_acc_out <= dec_acc;
      end
      // sticky seen bits, set wins over write clear
      if (go & dec_fault)
        stat_r[0] <= 1'b1;
      else if (wr_en && paddr == `ROD_STAT_OFF && pwdata[0])
        stat_r[0] <= 1'b0;
      if (go & dec_nop)
        stat_r[1] <= 1'b1;
      else if (wr_en && paddr == `ROD_STAT_OFF && pwdata[1])
        stat_r[1] <= 1'b0;
    end
  end
endmodule

// File: testbench/reserved_opcode_decode_bench.sv
`timescale 1ns/1ps
`include "rod_regs.vh"
`define CHK(n,e,s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module reserved_opcode_decode_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, er;
  logic        pslverr, fault, nopr, take;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  acc, lacc;
  logic [15:0] fw;
  int          failures, checks, i;

  rod_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .invalid_opcode_fault(fault), .nop_retire(nopr), .low_acc_out(acc));
  rod_fetch_model u_fetch (.pclk(pclk), .take(take), .word(fw));

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask

  function automatic logic exp_fault(input logic lg, es, input logic [7:0] o);
    return es ? !(o == 8'h0d || o[7:3] == 5'h03)
              : lg && (o == 8'h82 || o == 8'hd6);
  endfunction

  // issue one opcode and compare pulses, result word and accumulator
  task automatic dec(input logic lg, cy, es, input logic [7:0] o, m);
    logic f;
    logic [2:0] r;
    f = exp_fault(lg, es, o);
    r = m[5:3];
    if (!es && o inside {8'hc0, 8'hc1, [8'hd0:8'hd3]} && r == 3'd6) r = 3'd4;
    if (!es && (o == 8'hf6 || o == 8'hf7) && r == 3'd1) r = 3'd0;
    if (!es && o == 8'hd6 && !lg) lacc = cy ? 8'hff : 8'h00;
    apb(1, `ROD_INSN_OFF, {14'h0, 1'b1, es, m, o});
    apb(1, `ROD_CTRL_OFF, {29'h0, 1'b1, cy, lg});
    @(posedge pclk); #1;
    `CHK("fault", f, fault)
    `CHK("nop", es && !f, nopr)
    apb(0, `ROD_RES_OFF, 0);
    if (!f && !es) `CHK("opreg", r, rd[22:20])
    if (!f && !es) `CHK("eff op", (o == 8'h82) ? 8'h80 : o, rd[19:12])
    if (es && !f) `CHK("nop res", 3'b111, {rd[26:25], rd[23]})
    `CHK("acc", lacc, acc)
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop();
  end

  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    take = 0; lacc = 0; failures = 0; checks = 0;
    void'($urandom(32'h5080485b));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, `ROD_FLAGS_OFF, 0); `CHK("flags", `ROD_FLAGS_RST, rd)
    apb(0, `ROD_FEAT_OFF, 0);
    `CHK("feat 8 23", 2'b11, {rd[8], rd[23]})
    `CHK("feat 4 5", 2'b11, {rd[4], rd[5]})
    `CHK("feat 0 15", 2'b11, {rd[0], rd[15]})
    apb(0, `ROD_FAM_OFF, 0); `CHK("family", 4'h6, rd[11:8])
    apb(1, `ROD_FLAGS_OFF, 32'h0020_0000); apb(0, `ROD_FLAGS_OFF, 0);
    `CHK("id set", 32'h0020_0002, rd)
    apb(1, `ROD_FLAGS_OFF, 0); apb(0, `ROD_FLAGS_OFF, 0);
    `CHK("id clr", 32'h0000_0002, rd)
    apb(0, 12'h01c, 0); `CHK("slverr", 1'b1, er)
    for (i = 0; i < 8; i++) dec(0, 0, 0, 8'h82, {2'b11, 3'(i), 3'h0});
    dec(1, 0, 0, 8'h82, 8'hc0);
    for (i = 0; i < 6; i++)
      dec(0, 0, 0, i < 2 ? 8'hc0 + 8'(i) : 8'hce + 8'(i), 8'hf0);
    dec(0, 0, 0, 8'hf6, 8'hc8); dec(0, 0, 0, 8'hf7, 8'hc8);
    dec(0, 0, 1, 8'h0d, 8'h05);
    for (i = 8'h18; i < 8'h20; i++) dec(1, 0, 1, 8'(i), 8'(i));
    dec(0, 1, 0, 8'hd6, 8'h00); dec(0, 0, 0, 8'hd6, 8'h00);
    dec(0, 1, 0, 8'hd6, 8'h00); dec(1, 0, 0, 8'hd6, 8'h00);
    dec(0, 0, 1, 8'h24, 8'hc0); dec(0, 0, 1, 8'h26, 8'hc0);
    dec(0, 0, 1, 8'h0b, 8'h00);
    repeat (40) begin
      take <= 1;
      @(posedge pclk);
      take <= 0;
      @(posedge pclk);
      dec(1'($urandom), 1'($urandom), 1'($urandom), fw[7:0], fw[15:8]);
    end
    report_and_stop();
  end
endmodule

// File: testbench/rod_chk_sva.sv
`timescale 1ns/1ps
`include "rod_regs.vh"
// port-level checker for the decoder top
module rod_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        invalid_opcode_fault,
  input wire logic        nop_retire,
  input wire logic [7:0]  low_acc_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && !penable ##1 psel && penable; endsequence
  logic go_req;    // control write with go bit completing this edge
  assign go_req = psel && penable && pready && pwrite && paddr == 12'h000
    && pwdata[2];
  property p_ready_once; s_access |=> pready ##1 !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready timing");
  property p_ready_in_access; pready |-> psel && penable; endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");
  property p_err_map; pready |-> pslverr == (paddr > 12'h018 || paddr[1:0] != 0);
  endproperty
  a_err_map: assert property (p_err_map) else $error("slverr wrong");
  property p_fault_cause; invalid_opcode_fault |-> $past(go_req, 2);
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("stray fault");
  property p_nop_cause; nop_retire |-> $past(go_req, 2); endproperty
  a_nop_cause: assert property (p_nop_cause) else $error("stray nop");
  property p_excl; !(invalid_opcode_fault && nop_retire); endproperty
  a_excl: assert property (p_excl) else $error("fault with nop");
  property p_pulse; invalid_opcode_fault |=> !invalid_opcode_fault; endproperty
  a_pulse: assert property (p_pulse) else $error("fault too long");
  property p_acc_vals; low_acc_out == 8'h00 || low_acc_out == 8'hff; endproperty
  a_acc_vals: assert property (p_acc_vals) else $error("acc value");
  property p_acc_cause; !$stable(low_acc_out) |-> $past(go_req, 2)
    && !$past(pwdata[0], 2) && low_acc_out == {8{$past(pwdata[1], 2)}};
  endproperty
  a_acc_cause: assert property (p_acc_cause) else $error("acc cause");
endmodule

bind rod_top rod_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .invalid_opcode_fault(invalid_opcode_fault), .nop_retire(nop_retire),
  .low_acc_out(low_acc_out));

// File: testbench/rod_fetch_model.sv
`timescale 1ns/1ps
// fetch stream: hands out one {modrm, opcode} pair per take pulse
module rod_fetch_model (
  input  wire logic        pclk,
  input  wire logic        take,
  output logic      [15:0] word
);
  logic [7:0] pick [4]; // aliased encodings kept in the mix

  initial begin
    pick = '{8'h82, 8'hd6, 8'hc1, 8'hf7};
    word = 16'h0;
  end

  // aliases mixed in
  // real code avoids aliases; the stream still sends them to stress decode
  always @(posedge pclk) begin
    if (take)
      word <= {8'($urandom), 1'($urandom) ? pick[2'($urandom)] : 8'($urandom)};
  end
endmodule
